/* File: core/vgs_pkg.sv */
/*
 * Shared constants of the VGA general and sequencer register bank:
 * register indices, field positions, write masks and reset values.
 * Assumes a 32-bit APB master placing each register on one aligned word.
 */
package vgs_pkg;

    // ****************************************************************
    // Register indices (byte address = 4 * index)
    // ****************************************************************
    localparam logic [9:0] IDX_MISC_WR_STAT0 = 10'h3c2; // Misc write, status 0 read
    localparam logic [9:0] IDX_VID_SUB_EN = 10'h3c3; // Video subsystem enable
    localparam logic [9:0] IDX_SEQ_INDEX = 10'h3c4; // Sequencer index
    localparam logic [9:0] IDX_SEQ_DATA = 10'h3c5; // Sequencer data
    localparam logic [9:0] IDX_FEAT_RD = 10'h3ca; // Feature control read
    localparam logic [9:0] IDX_MISC_RD = 10'h3cc; // Misc output read
    localparam logic [9:0] IDX_FEAT_STAT1_MONO = 10'h3ba; // 3?A at mono base
    localparam logic [9:0] IDX_FEAT_STAT1_COLOUR = 10'h3da; // 3?A at colour base

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MISC_COLOUR_EMU = 0;
    localparam int MISC_CPU_MEM_EN = 1;
    localparam int MISC_DOT_CLK_LO = 2;
    localparam int MISC_HIGH_PAGE = 5;
    localparam int MISC_HSYNC_LOW = 6;
    localparam int MISC_VSYNC_LOW = 7;
    localparam int FEAT_VSYNC_OR_DE = 3;
    localparam int STAT0_SENSE = 4;
    localparam int STAT0_VR_IRQ = 7;
    localparam int STAT1_NOT_ACTIVE = 0;
    localparam int STAT1_FIXED_ONE = 2;
    localparam int STAT1_VRETRACE = 3;
    localparam int STAT1_FEEDBACK_LO = 4;
    localparam int CLK_8DOT = 0;
    localparam int CLK_LOAD2 = 2;
    localparam int CLK_HALF = 3;
    localparam int CLK_LOAD4 = 4;
    localparam int CLK_SCREEN_OFF = 5;
    localparam int MEM_256K = 1;
    localparam int MEM_SEQUENTIAL = 2;

    // Dot clock select code that also opens PLL parameter loading
    localparam logic [1:0] DOT_CLK_PLL_LOAD = 2'h3;

    // ****************************************************************
    // Writable bit masks and reset values
    // ****************************************************************
    localparam logic [7:0] MASK_MISC = 8'hef;
    localparam logic [7:0] MASK_FEAT = 8'h08;
    localparam logic [7:0] MASK_VID_SUB = 8'h01;
    localparam logic [7:0] MASK_SEQ_INDEX = 8'h1f;
    localparam logic [7:0] MASK_SEQ_RESET = 8'h03;
    localparam logic [7:0] MASK_SEQ_CLOCKING = 8'h3d;
    localparam logic [7:0] MASK_SEQ_PLANE = 8'h0f;
    localparam logic [7:0] MASK_SEQ_FONT = 8'h3f;
    localparam logic [7:0] MASK_SEQ_MEMORY = 8'h06;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [4:0] RST_SEQ_INDEX = 5'h00;
    localparam int SEQ_COUNT = 5; // Indexed sequencer registers 00..04

endpackage : vgs_pkg

/* File: core/vgs_pin_sync.sv */
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes the pins change asynchronously to i_clock.
 */
`timescale 1ns/1ps
`default_nettype none
module vgs_pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Pin side
    input wire logic [WIDTH-1:0] i_pin,
    // Synchronised side
    output logic [WIDTH-1:0] o_level
);

    // ****************************************************************
    // Three flip-flops, then accept a bit once stages two and three agree
    // ****************************************************************
    logic [WIDTH-1:0] stage1_ff; // Read only by stage2
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] level_ff;

    // Shift chain
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
        end else begin
            stage1_ff <= i_pin;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // Agreement filter per bit
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            level_ff <= '0;
        end else begin
            for (int b = 0; b < WIDTH; b++) begin
                if (stage2_ff[b] == stage3_ff[b]) begin
                    level_ff[b] <= stage3_ff[b];
                end
            end
        end
    end

    assign o_level = level_ff;

endmodule : vgs_pin_sync
`default_nettype wire

/* File: core/vgs_regs.sv */
/*
 * VGA general (external) and sequencer register bank behind an APB slave.
 * Drives sync polarity, clock select, memory access and serializer controls.
 * Assumes display timing inputs come from logic on i_clock; sense and
 * colour feedback arrive from pins and are synchronised here.
 */
// What this block does
// - Misc bit0 moves the 3?A register to colour base
// - Misc bit1 clear blocks CPU memory accesses
// - Misc bits3-2 pick dot clock, enable PLL load
// - Misc bit5 selects upper 64K page
// - Misc bits6,7 make hsync, vsync active low
// - Feature bit3 ORs vsync with display enable
// - Status0 bit4 reads monitor sense level
// - Status0 bit7 shows pending retrace interrupt
// - Status1 bit0 set outside active display
// - Status1 bit3 set during vertical retrace
// - Status1 bits5-4 return colour output feedback
// - Host writes 5-bit index; device keeps it
// - Data port reads/writes register named by index
// - Reset control bits stored, no effect
// - Clocking bit0 selects 8-dot characters, else 9
// - Clocking bits2,4 load serializers every 2nd/4th
// - Clocking bit3 halves character clock
// - Clocking bit5 blanks the screen
// - Plane enable bits gate CPU plane writes
// - Memory mode bit1 allows 256K access
// - Memory mode bit2 selects sequential addressing
`timescale 1ns/1ps
`default_nettype none
module vgs_regs
    import vgs_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Display timing from the CRT pipeline (same clock)
    input wire logic i_hsync_raw,
    input wire logic i_vsync_raw,
    input wire logic i_display_enable,
    input wire logic i_vretrace,
    input wire logic i_vretrace_irq_pending,
    // Pins
    input wire logic i_monitor_sense,
    input wire logic [1:0] i_colour_feedback,
    // CPU memory request from the host bridge
    input wire logic i_cpu_mem_req,
    input wire logic i_cpu_mem_write,
    // Sync outputs
    output logic o_hsync,
    output logic o_vsync,
    // Memory access controls
    output logic o_colour_emulation,
    output logic o_cpu_mem_grant,
    output logic [3:0] o_plane_write_strobe,
    output logic o_high_page_select,
    output logic o_mem_256k,
    output logic o_sequential_addr,
    // Clock and serializer controls
    output logic [1:0] o_dot_clock_select,
    output logic o_pll_load_enable,
    output logic o_char_8dot,
    output logic o_serial_load_2,
    output logic o_serial_load_4,
    output logic o_char_clock_half,
    output logic o_screen_off,
    output logic o_vga_enable,
    output logic [2:0] o_font_a,
    output logic [2:0] o_font_b
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Word index hit on the byte address
    function automatic logic addr_hit(input logic [11:0] addr, input logic [9:0] idx);
        addr_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
    endfunction : addr_hit

    // Writable mask of an indexed sequencer register
    function automatic logic [7:0] seq_mask(input logic [4:0] idx);
        case (idx)
            5'h00: seq_mask = MASK_SEQ_RESET;
            5'h01: seq_mask = MASK_SEQ_CLOCKING;
            5'h02: seq_mask = MASK_SEQ_PLANE;
            5'h03: seq_mask = MASK_SEQ_FONT;
            5'h04: seq_mask = MASK_SEQ_MEMORY;
            default: seq_mask = 8'h00;
        endcase
    endfunction : seq_mask

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0] misc_ff; // Miscellaneous output
    logic [7:0] feat_ff; // Feature control
    logic [7:0] vid_sub_ff; // Video subsystem enable
    logic [4:0] seq_index_ff; // Sequencer index
    logic [7:0] seq_regs_ff [SEQ_COUNT]; // Indexed sequencer registers
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic hsync_ff;
    logic vsync_ff;
    logic grant_ff;
    logic [3:0] plane_strobe_ff;
    logic [7:0] ctl_misc_ff; // Copies feeding the pipeline outputs
    logic [7:0] ctl_clk_ff;
    logic [7:0] ctl_mem_ff;
    logic [7:0] ctl_font_ff;
    logic vga_en_ff;
    logic pll_load_ff; // Dot clock select asks for PLL parameter loading
    // Synchronised pin levels
    logic sense_lvl;
    logic [1:0] feedback_lvl;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    vgs_pin_sync #(.WIDTH(3)) u_pin_sync (
        .i_clock(i_clock), .i_rst(i_rst),
        .i_pin({i_monitor_sense, i_colour_feedback}), .o_level({sense_lvl, feedback_lvl})
    );

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic [9:0] idx_stat1; // 3?A follows the emulation base
    logic hit_misc_stat0;
    logic hit_vid_sub;
    logic hit_seq_index;
    logic hit_seq_data;
    logic hit_feat_rd;
    logic hit_misc_rd;
    logic hit_stat1;
    logic hit_any;
    logic wr_ok; // Access edge of a write carrying the low byte
    logic [7:0] wbyte;

    assign idx_stat1 = misc_ff[MISC_COLOUR_EMU] ? IDX_FEAT_STAT1_COLOUR
                                                 : IDX_FEAT_STAT1_MONO;
    assign hit_misc_stat0 = addr_hit(i_paddr, IDX_MISC_WR_STAT0);
    assign hit_vid_sub = addr_hit(i_paddr, IDX_VID_SUB_EN);
    assign hit_seq_index = addr_hit(i_paddr, IDX_SEQ_INDEX);
    assign hit_seq_data = addr_hit(i_paddr, IDX_SEQ_DATA);
    assign hit_feat_rd = addr_hit(i_paddr, IDX_FEAT_RD);
    assign hit_misc_rd = addr_hit(i_paddr, IDX_MISC_RD);
    assign hit_stat1 = addr_hit(i_paddr, idx_stat1);
    assign hit_any = hit_misc_stat0 | hit_vid_sub | hit_seq_index | hit_seq_data
                   | hit_feat_rd | hit_misc_rd | hit_stat1;
    assign wr_ok = i_psel & i_penable & i_pwrite & i_pstrb[0];
    assign wbyte = i_pwdata[7:0];

    // ****************************************************************
    // Read data mux
    // ****************************************************************
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit_misc_stat0) begin
            rd_byte[STAT0_SENSE] = sense_lvl;
            rd_byte[STAT0_VR_IRQ] = i_vretrace_irq_pending;
        end else if (hit_stat1) begin
            rd_byte[STAT1_NOT_ACTIVE] = ~i_display_enable;
            rd_byte[STAT1_FIXED_ONE] = 1'b1;
            rd_byte[STAT1_VRETRACE] = i_vretrace;
            rd_byte[STAT1_FEEDBACK_LO +: 2] = feedback_lvl;
        end else if (hit_vid_sub) begin
            rd_byte = vid_sub_ff;
        end else if (hit_seq_index) begin
            rd_byte = {3'h0, seq_index_ff};
        end else if (hit_seq_data) begin
            if (seq_index_ff < 5'(SEQ_COUNT)) begin
                rd_byte = seq_regs_ff[seq_index_ff[2:0]];
            end
        end else if (hit_feat_rd) begin
            rd_byte = feat_ff;
        end else if (hit_misc_rd) begin
            rd_byte = misc_ff;
        end
    end

    // ****************************************************************
    // APB answer: data captured in setup, zero-wait access phase
    // ****************************************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= 1'b1;
            if (i_psel && !i_penable) begin
                // Setup cycle: prepare the answer
                prdata_ff <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                pslverr_ff <= ~hit_any;
            end
        end
    end

    // ****************************************************************
    // General register writes
    // ****************************************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            misc_ff <= RST_REG;
            feat_ff <= RST_REG;
            vid_sub_ff <= RST_REG;
        end else if (wr_ok) begin
            if (hit_misc_stat0) begin
                misc_ff <= wbyte & MASK_MISC;
            end
            if (hit_stat1) begin
                feat_ff <= wbyte & MASK_FEAT;
            end
            if (hit_vid_sub) begin
                vid_sub_ff <= wbyte & MASK_VID_SUB;
            end
        end
    end

    // ****************************************************************
    // Sequencer index and data
    // ****************************************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            seq_index_ff <= RST_SEQ_INDEX;
        end else if (wr_ok && hit_seq_index) begin
            seq_index_ff <= wbyte[4:0];
        end
    end

    // Indexed registers; index 00 is stored only
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < SEQ_COUNT; i++) begin
                seq_regs_ff[i] <= RST_REG;
            end
        end else if (wr_ok && hit_seq_data && seq_index_ff < 5'(SEQ_COUNT)) begin
            seq_regs_ff[seq_index_ff[2:0]] <= wbyte & seq_mask(seq_index_ff);
        end
    end

    // ****************************************************************
    // Control copies toward the display pipeline
    // ****************************************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ctl_misc_ff <= RST_REG;
            ctl_clk_ff <= RST_REG;
            ctl_mem_ff <= RST_REG;
            ctl_font_ff <= RST_REG;
            vga_en_ff <= 1'b0;
            pll_load_ff <= 1'b0;
        end else begin
            ctl_misc_ff <= misc_ff;
            ctl_clk_ff <= seq_regs_ff[1];
            ctl_mem_ff <= seq_regs_ff[4];
            ctl_font_ff <= seq_regs_ff[3];
            vga_en_ff <= vid_sub_ff[0];
            pll_load_ff <= misc_ff[MISC_DOT_CLK_LO +: 2] == DOT_CLK_PLL_LOAD;
        end
    end

    // ****************************************************************
    // Sync outputs with programmable polarity
    // ****************************************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            hsync_ff <= 1'b0;
            vsync_ff <= 1'b0;
        end else begin
            hsync_ff <= i_hsync_raw ^ misc_ff[MISC_HSYNC_LOW];
            vsync_ff <= (i_vsync_raw | (feat_ff[FEAT_VSYNC_OR_DE] & i_display_enable))
                        ^ misc_ff[MISC_VSYNC_LOW];
        end
    end

    // ****************************************************************
    // CPU memory gating
    // ****************************************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            grant_ff <= 1'b0;
            plane_strobe_ff <= 4'h0;
        end else begin
            grant_ff <= i_cpu_mem_req & misc_ff[MISC_CPU_MEM_EN];
            plane_strobe_ff <= {4{i_cpu_mem_req & i_cpu_mem_write
                                  & misc_ff[MISC_CPU_MEM_EN]}}
                               & seq_regs_ff[2][3:0];
        end
    end

    // ****************************************************************
    // Output assignments
    // ****************************************************************
    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_hsync = hsync_ff;
    assign o_vsync = vsync_ff;
    assign o_cpu_mem_grant = grant_ff;
    assign o_plane_write_strobe = plane_strobe_ff;
    assign o_colour_emulation = ctl_misc_ff[MISC_COLOUR_EMU];
    assign o_dot_clock_select = ctl_misc_ff[MISC_DOT_CLK_LO +: 2];
    assign o_pll_load_enable = pll_load_ff;
    assign o_high_page_select = ctl_misc_ff[MISC_HIGH_PAGE];
    assign o_char_8dot = ctl_clk_ff[CLK_8DOT];
    assign o_serial_load_2 = ctl_clk_ff[CLK_LOAD2];
    assign o_serial_load_4 = ctl_clk_ff[CLK_LOAD4];
    assign o_char_clock_half = ctl_clk_ff[CLK_HALF];
    assign o_screen_off = ctl_clk_ff[CLK_SCREEN_OFF];
    assign o_mem_256k = ctl_mem_ff[MEM_256K];
    assign o_sequential_addr = ctl_mem_ff[MEM_SEQUENTIAL];
    assign o_font_b = {ctl_font_ff[4], ctl_font_ff[1:0]};
    assign o_font_a = {ctl_font_ff[5], ctl_font_ff[3:2]};
    assign o_vga_enable = vga_en_ff;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    AST_COLOUR_BASE: assert property (wr_ok && hit_misc_stat0 && wbyte[0]
        |=> ##1 o_colour_emulation)
        else $error("colour emulation not applied");
    AST_MEM_BLOCK: assert property (!misc_ff[1] |=> !o_cpu_mem_grant)
        else $error("cpu access granted while disabled");
    AST_PLL_LOAD: assert property (o_pll_load_enable == ($past(misc_ff[3:2]) == 2'h3))
        else $error("pll load enable mismatch");
    AST_HIGH_PAGE: assert property (wr_ok && hit_misc_stat0
        |=> ##1 o_high_page_select == $past(wbyte[5], 2))
        else $error("high page select wrong");
    AST_HSYNC_POL: assert property (o_hsync == ($past(i_hsync_raw) ^ $past(misc_ff[6])))
        else $error("hsync polarity wrong");
    AST_VSYNC_DE: assert property (feat_ff[3] && i_display_enable && !misc_ff[7]
        |=> o_vsync)
        else $error("vsync not ORed with display enable");
    AST_STAT1_ONE: assert property (i_psel && !i_penable && !i_pwrite && hit_stat1
        |=> o_prdata[2] && o_prdata[0] != $past(i_display_enable))
        else $error("status 1 read wrong");
    AST_INDEX_KEEP: assert property (!(wr_ok && hit_seq_index)
        |=> $stable(seq_index_ff))
        else $error("sequencer index changed");
    AST_SEQ_RESERVED: assert property (wr_ok && hit_seq_data && seq_index_ff == 5'h01
        |=> seq_regs_ff[1][7:6] == 2'h0 && seq_regs_ff[1][1] == 1'b0)
        else $error("reserved clocking bits stored");
    AST_PLANE_GATE: assert property ((o_plane_write_strobe & ~$past(seq_regs_ff[2][3:0]))
        == 4'h0)
        else $error("write to disabled plane");
    AST_SCREEN_OFF: assert property (wr_ok && hit_seq_data && seq_index_ff == 5'h01
        |=> ##1 o_screen_off == $past(wbyte[5], 2))
        else $error("screen off not applied");

    COV_SEQ_WRITE: cover property (wr_ok && hit_seq_data);
    COV_STAT1_READ: cover property (i_psel && !i_penable && hit_stat1);
    COV_UNMAPPED: cover property (i_psel && i_penable && o_pslverr);
endmodule : vgs_regs
`default_nettype wire

/* File: sim/vgs_host_model.sv */
/*
 * Host CPU model: an APB master that runs one register transfer per call.
 * Assumes the slave shares i_clock and answers with pready.
 */
`timescale 1ns/1ps
`default_nettype none
module vgs_host_model (
    // Clock
    input wire logic i_clock,
    // APB master side
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [11:0] o_paddr,
    output logic [31:0] o_pwdata,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr
);
    // Bus idle at time zero
    initial begin
        {o_psel, o_penable, o_pwrite} = 3'h0;
        o_paddr = 12'h000;
        o_pwdata = 32'h0000_0000;
    end

    // One transfer: setup, access held until pready, then release
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge i_clock);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= wr;
        o_paddr <= addr;
        o_pwdata <= wd;
        @(posedge i_clock);
        o_penable <= 1'b1;
        @(posedge i_clock);
        while (i_pready !== 1'b1) @(posedge i_clock);
        rd = i_prdata;
        err = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // Released data no longer shows the last value
        o_pwdata <= ~wd;
    endtask : xfer
endmodule : vgs_host_model
`default_nettype wire

/* File: sim/test_vgs_regs.sv */
/*
 * Self-checking bench of the VGA general and sequencer register bank.
 * Assumes the host model runs the APB cycles; pins driven here.
 */
`timescale 1ns/1ps
`default_nettype none
module test_vgs_regs
    import vgs_pkg::*;
;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic i_clock = 1'b0;
    logic i_rst;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic hs, vs, de, vr, irq, sense, req, mw;
    logic [1:0] cfb, dsel;
    logic hsync, vsync, cemu, grant, hpage, m256, sqa, pll, c8, l2, l4, half, off, ven;
    logic [3:0] strobe;
    logic [2:0] font_a, font_b;
    int miscompares = 0;
    int checks_done = 0;
    // Writable masks of the five sequencer registers
    logic [7:0] msk [5] = '{8'h03, 8'h3d, 8'h0f, 8'h3f, 8'h06};

    always #2 i_clock = ~i_clock;

    vgs_host_model u_host (.i_clock(i_clock), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
        .i_pready(pready), .i_pslverr(pslverr));

    vgs_regs u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'h1),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_hsync_raw(hs),
        .i_vsync_raw(vs), .i_display_enable(de), .i_vretrace(vr),
        .i_vretrace_irq_pending(irq), .i_monitor_sense(sense), .i_colour_feedback(cfb),
        .i_cpu_mem_req(req), .i_cpu_mem_write(mw), .o_hsync(hsync), .o_vsync(vsync),
        .o_colour_emulation(cemu), .o_cpu_mem_grant(grant), .o_plane_write_strobe(strobe),
        .o_high_page_select(hpage), .o_mem_256k(m256), .o_sequential_addr(sqa),
        .o_dot_clock_select(dsel), .o_pll_load_enable(pll), .o_char_8dot(c8),
        .o_serial_load_2(l2), .o_serial_load_4(l4), .o_char_clock_half(half),
        .o_screen_off(off), .o_vga_enable(ven), .o_font_a(font_a), .o_font_b(font_b));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b1, {idx, 2'b00}, {24'h0, d}, r, e);
    endtask : wr

    task automatic rd(input string nm, input logic [9:0] idx, input logic [7:0] exp,
                      input logic err);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b0, {idx, 2'b00}, 32'h0, r, e);
        chk(nm, {24'h0, exp}, r);
        chk({nm, "_err"}, {31'h0, err}, {31'h0, e});
    endtask : rd

    // Let register outputs land, then sample off the edge
    task automatic settle();
        repeat (3) @(posedge i_clock);
        #1;
    endtask : settle

    // One CPU write request pulse, grant and strobes a cycle later
    task automatic cpu(input logic [4:0] exp);
        @(posedge i_clock);
        req <= 1'b1;
        @(posedge i_clock);
        req <= 1'b0;
        #1;
        chk("cpu_mem", {27'h0, exp}, {27'h0, grant, strobe});
    endtask : cpu

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {hs, vs, de, vr, irq, sense, req} = 7'h10; // Display enable starts high
        mw = 1'b1;
        cfb = 2'h0;
        i_rst = 1'b1;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        // Misc output: reserved bit dropped, colour base moves status 1
        rd("misc_rst", IDX_MISC_RD, 8'h00, 1'b0);
        wr(IDX_MISC_WR_STAT0, 8'hff);
        rd("misc", IDX_MISC_RD, 8'hef, 1'b0);
        settle();
        chk("misc_out", 32'h1f, {27'h0, cemu, hpage, dsel, pll});
        wr(IDX_FEAT_STAT1_COLOUR, 8'hff);
        rd("feat", IDX_FEAT_RD, 8'h08, 1'b0);
        rd("mono", IDX_FEAT_STAT1_MONO, 8'h00, 1'b1);
        $display("test misc done");
        // Sync polarity and display enable merge
        settle();
        chk("sync_low", 32'h2, {30'h0, hsync, vsync});
        wr(IDX_MISC_WR_STAT0, 8'h0f);
        @(posedge i_clock);
        {hs, vs} <= 2'h3;
        de <= 1'b0;
        settle();
        chk("sync_high", 32'h3, {30'h0, hsync, vsync});
        chk("page", 32'h2, {30'h0, cemu, hpage});
        $display("test sync done");
        // Status registers follow pins and timing
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clock);
            {sense, irq, vr} <= {3{k[0]}};
            de <= !k[0];
            cfb <= {k[0], !k[0]};
            repeat (8) @(posedge i_clock);
            rd("stat0", IDX_MISC_WR_STAT0, k ? 8'h90 : 8'h00, 1'b0);
            rd("stat1", IDX_FEAT_STAT1_COLOUR, k ? 8'h2d : 8'h14, 1'b0);
        end
        $display("test status done");
        // Sequencer index and data pair
        wr(IDX_SEQ_INDEX, 8'hff);
        rd("index", IDX_SEQ_INDEX, 8'h1f, 1'b0);
        for (int i = 0; i < 6; i++) begin
            wr(IDX_SEQ_INDEX, 8'(i));
            wr(IDX_SEQ_DATA, 8'hff);
            rd("seq", IDX_SEQ_DATA, (i < 5) ? msk[i] : 8'h00, 1'b0);
        end
        settle();
        chk("clk_out", 32'h1f, {c8, l2, half, l4, off});
        chk("mem_out", 32'hff, {m256, sqa, font_a, font_b});
        $display("test sequencer done");
        // CPU memory gate and plane write enables
        wr(IDX_SEQ_INDEX, 8'h02);
        wr(IDX_SEQ_DATA, 8'h05);
        settle();
        cpu(5'h15);
        wr(IDX_MISC_WR_STAT0, 8'h0d);
        settle();
        cpu(5'h00);
        wr(IDX_VID_SUB_EN, 8'hff);
        rd("vid_en", IDX_VID_SUB_EN, 8'h01, 1'b0);
        settle();
        chk("vga_en", 32'h1, {31'h0, ven});
        $display("test cpu memory done");
        end_sim();
    end

    // Watchdog far beyond the expected run of under 200 cycles
    initial begin
        #40000;
        miscompares++;
        end_sim();
    end
endmodule : test_vgs_regs
`default_nettype wire
